// *** shared/adc_readout_pkg.sv ***
// constants, types and states shared by the converter readout port
package adc_readout_pkg;
   localparam int WORD_W = 24;
   localparam int RAW_W = 26;
   localparam int CNT_W = 20;
   localparam int REF_CLK_HZ = 2457600;
   localparam int REF_SPS = 15;
   localparam int POWERUP_MS = 350;
   // counts are in device clocks, so the rate follows the clock frequency
   localparam int CONV_CYCLES_DEF = REF_CLK_HZ / REF_SPS;
   localparam int CAL_CYCLES_DEF = (POWERUP_MS * REF_CLK_HZ) / 1000;
   localparam int UPDATE_CYCLES = 16;
   localparam int SLEEP_CYCLES_DEF = 2000;
   localparam int FIFO_DEPTH_DEF = 8;
   localparam logic [4:0] MSB_IDX = 5'h17;
   localparam logic [4:0] BITS_DONE = 5'h18;
   localparam logic [4:0] FORCED_HIGH = 5'h19;
   localparam logic [4:0] CAL_ARMED = 5'h1a;
   localparam logic [4:0] NO_DATA = 5'h1b;
   localparam logic [WORD_W-1:0] CODE_POS_FS = 24'h7fffff;
   localparam logic [WORD_W-1:0] CODE_NEG_FS = 24'h800000;
   localparam logic signed [RAW_W-1:0] RAW_POS_FS = 26'sh07fffff;
   localparam logic signed [RAW_W-1:0] RAW_NEG_FS = 26'sh3800000;

   typedef enum logic [1:0] {
      ST_CAL = 2'b00,
      ST_CONV = 2'b01,
      ST_UPDATE = 2'b10,
      ST_SLEEP = 2'b11
   } seq_state_t;

   typedef struct packed {
      logic signed [RAW_W-1:0] value;
   } raw_sample_t;

   typedef struct packed {
      logic [WORD_W-1:0] code;
   } result_word_t;
endpackage

// *** logic/adc_serial_readout_port.sv ***
// result fifo and the readout/sequencing logic of the serial converter port
module result_fifo #(
   parameter int W = 24,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire [AW-1:0] wr_ptr_inc = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
   wire [AW-1:0] rd_ptr_inc = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;

   assign in_ready = (count_r != (AW + 1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data = mem[rd_ptr_r];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_inc;
         if (pop) rd_ptr_r <= rd_ptr_inc;
         count_r <= count_r + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule

module adc_serial_readout_port
   import adc_readout_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYCLES_DEF,
   parameter int CAL_CYCLES = CAL_CYCLES_DEF,
   parameter int SLEEP_CYCLES = SLEEP_CYCLES_DEF,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic serial_shift_clock,
   input wire raw_sample_t raw_in,
   input wire logic raw_valid,
   output logic raw_ready,
   output logic ready_data_out,
   output logic conv_start,
   output logic calibrating,
   output logic asleep
);
   localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);
   localparam logic [CNT_W-1:0] UPD_LAST = CNT_W'(UPDATE_CYCLES - 1);
   localparam logic [CNT_W-1:0] UPD_START = CNT_W'(CONV_CYCLES - UPDATE_CYCLES - 1);
   localparam logic [CNT_W-1:0] SLEEP_LAST = CNT_W'(SLEEP_CYCLES - 1);

   logic sclk_meta_r;
   logic sclk_sync_r;
   logic sclk_prev_r;
   seq_state_t state_r;
   seq_state_t state_nxt;
   logic [CNT_W-1:0] timer_r;
   logic [CNT_W-1:0] timer_nxt;
   logic [CNT_W-1:0] hold_r;
   logic [4:0] bit_cnt_r;
   logic [4:0] bit_cnt_nxt;
   logic line_r;
   logic line_nxt;
   logic cal_wake_r;
   logic cal_wake_nxt;
   logic conv_start_r;
   logic conv_start_nxt;
   logic fifo_pop;
   result_word_t out_word_r;
   result_word_t out_word_nxt;
   result_word_t clip_word;
   result_word_t fifo_word;
   logic fifo_valid;

   // first stage feeds only the second; edges are found on the settled copy
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sclk_meta_r <= 1'b0;
         sclk_sync_r <= 1'b0;
         sclk_prev_r <= 1'b0;
      end else begin
         sclk_meta_r <= serial_shift_clock;
         sclk_sync_r <= sclk_meta_r;
         sclk_prev_r <= sclk_sync_r;
      end
   end

   wire sclk_rise = sclk_sync_r && !sclk_prev_r;
   wire sclk_fall = !sclk_sync_r && sclk_prev_r;

   // saturate filter output to the 24-bit two's complement range
   wire raw_over = raw_in.value > RAW_POS_FS;
   wire raw_under = raw_in.value < RAW_NEG_FS;
   assign clip_word.code = raw_over ? CODE_POS_FS :
                           raw_under ? CODE_NEG_FS :
                           raw_in.value[WORD_W-1:0];

   result_fifo #(
      .W(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .in_data(clip_word.code),
      .in_valid(raw_valid),
      .in_ready(raw_ready),
      .out_data(fifo_word.code),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   wire [4:0] bit_idx = MSB_IDX - bit_cnt_r;
   wire shift_bit = out_word_r.code[bit_idx];
   wire reading = (bit_cnt_r < BITS_DONE);
   wire has_result = (bit_cnt_r != NO_DATA);
   // a high phase much longer than any shift pulse means the host asks for sleep
   wire hold_high = (state_r == ST_CONV) && sclk_sync_r && has_result;
   wire sleep_due = hold_high && (hold_r == SLEEP_LAST);
   wire [CNT_W-1:0] hold_nxt = hold_high ? hold_r + 1'b1 : '0;
   wire cal_pending = (bit_cnt_r == FORCED_HIGH) || (bit_cnt_r == CAL_ARMED);

   always_comb begin
      state_nxt = state_r;
      timer_nxt = timer_r;
      bit_cnt_nxt = bit_cnt_r;
      line_nxt = line_r;
      cal_wake_nxt = cal_wake_r;
      conv_start_nxt = 1'b0;
      out_word_nxt = out_word_r;
      fifo_pop = 1'b0;
      case (state_r)
         ST_CAL: begin
            line_nxt = 1'b1;
            bit_cnt_nxt = NO_DATA;
            if (timer_r == CAL_LAST) begin
               state_nxt = ST_UPDATE;
               timer_nxt = '0;
            end else begin
               timer_nxt = timer_r + 1'b1;
            end
         end
         ST_UPDATE: begin
            line_nxt = 1'b1;
            if (timer_r == UPD_LAST) begin
               state_nxt = ST_CONV;
               timer_nxt = '0;
               bit_cnt_nxt = '0;
               line_nxt = 1'b0;
               conv_start_nxt = 1'b1;
               fifo_pop = fifo_valid;
               // an unread word is replaced here whether or not the host finished
               if (fifo_valid) out_word_nxt = fifo_word;
            end else begin
               timer_nxt = timer_r + 1'b1;
            end
         end
         ST_CONV: begin
            timer_nxt = timer_r + 1'b1;
            if (timer_r == UPD_START) begin
               state_nxt = ST_UPDATE;
               timer_nxt = '0;
               line_nxt = 1'b1;
            end else if (sleep_due) begin
               state_nxt = ST_SLEEP;
               line_nxt = 1'b1;
               cal_wake_nxt = cal_pending;
            end else if (sclk_fall && bit_cnt_r == CAL_ARMED) begin
               state_nxt = ST_CAL;
               timer_nxt = '0;
               line_nxt = 1'b1;
               bit_cnt_nxt = NO_DATA;
            end else if (sclk_rise && has_result) begin
               if (reading) begin
                  line_nxt = shift_bit;
                  bit_cnt_nxt = bit_cnt_r + 1'b1;
               end else if (bit_cnt_r == BITS_DONE) begin
                  line_nxt = 1'b1;
                  bit_cnt_nxt = FORCED_HIGH;
               end else if (bit_cnt_r == FORCED_HIGH) begin
                  bit_cnt_nxt = CAL_ARMED;
               end
            end
         end
         ST_SLEEP: begin
            line_nxt = 1'b1;
            if (!sclk_sync_r) begin
               state_nxt = cal_wake_r ? ST_CAL : ST_CONV;
               timer_nxt = '0;
               bit_cnt_nxt = NO_DATA;
               cal_wake_nxt = 1'b0;
            end
         end
         default: begin
            state_nxt = ST_CAL;
            timer_nxt = '0;
            line_nxt = 1'b1;
         end
      endcase
   end

   // reset is the power-up event: calibrate first, line high meanwhile
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_CAL;
         timer_r <= '0;
         hold_r <= '0;
         bit_cnt_r <= NO_DATA;
         line_r <= 1'b1;
         cal_wake_r <= 1'b0;
         conv_start_r <= 1'b0;
         out_word_r <= '0;
      end else begin
         state_r <= state_nxt;
         timer_r <= timer_nxt;
         hold_r <= hold_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         line_r <= line_nxt;
         cal_wake_r <= cal_wake_nxt;
         conv_start_r <= conv_start_nxt;
         out_word_r <= out_word_nxt;
      end
   end

   assign ready_data_out = line_r;
   assign conv_start = conv_start_r;
   assign calibrating = (state_r == ST_CAL);
   assign asleep = (state_r == ST_SLEEP);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   wire upd_done = (state_r == ST_UPDATE) && (timer_r == UPD_LAST);

   a_ready_goes_low: assert property (upd_done |=> !ready_data_out && conv_start)
      else $error("line not low with start after update");
   a_msb_first: assert property (
      (state_r == ST_CONV) && (state_nxt == ST_CONV) && sclk_rise && bit_cnt_r == '0
      |=> ready_data_out == out_word_r.code[WORD_W-1])
      else $error("first shifted bit is not the msb");
   a_next_bit: assert property (
      (state_r == ST_CONV) && (state_nxt == ST_CONV) && sclk_rise && reading
      |=> bit_cnt_r == $past(bit_cnt_r) + 5'h01 && ready_data_out == $past(shift_bit))
      else $error("shift did not present the next bit");
   a_forced_high: assert property (
      (state_r == ST_CONV) && (state_nxt == ST_CONV) && sclk_rise && bit_cnt_r == BITS_DONE
      |=> ready_data_out [*2])
      else $error("25th clock did not force the line high");
   a_hold_last: assert property (
      (state_r == ST_CONV) && (state_nxt == ST_CONV) && !sclk_rise && !sclk_fall
      |=> $stable(ready_data_out))
      else $error("line changed without a shift");
   a_update_high: assert property ((state_r == ST_UPDATE) |-> ready_data_out)
      else $error("line low during update");
   a_conv_period: assert property (
      (state_r == ST_CONV) && (timer_r == UPD_START) |=> (state_r == ST_UPDATE) [*8])
      else $error("conversion timer did not start the update");
   // overrange judged from sign and guard bits, independent of the comparators
   a_clip_pos: assert property (
      !raw_in.value[RAW_W-1] && raw_in.value[RAW_W-2:WORD_W-1] != '0
      |-> clip_word.code == CODE_POS_FS)
      else $error("positive overrange not clipped");
   a_clip_neg: assert property (
      raw_in.value[RAW_W-1] && raw_in.value[RAW_W-2:WORD_W-1] != '1
      |-> clip_word.code == CODE_NEG_FS)
      else $error("negative overrange not clipped");
   a_code_pass: assert property (
      raw_in.value == -26'sh0000001 |-> clip_word.code == 24'hffffff)
      else $error("minus one step code wrong");
   a_cal_start: assert property (
      (state_r == ST_CONV) && (timer_r != UPD_START) && !sleep_due && sclk_fall
      && bit_cnt_r == CAL_ARMED |=> calibrating ##1 ready_data_out)
      else $error("26th falling edge did not start calibration");
   a_cal_ends: assert property (
      calibrating && timer_r == CAL_LAST |=> (state_r == ST_UPDATE) ##16 !ready_data_out)
      else $error("calibration did not end in a result");
   a_sleep_high: assert property (asleep |-> ready_data_out)
      else $error("line low while asleep");
   a_edge_once: assert property (sclk_rise |=> !sclk_rise)
      else $error("one shift clock rise counted twice");

   c_full_read: cover property (sclk_rise && bit_cnt_r == BITS_DONE && state_r == ST_CONV);
   c_cal_by_host: cover property (sclk_fall && bit_cnt_r == CAL_ARMED && state_r == ST_CONV);
   c_sleep_wake: cover property (asleep ##1 !asleep);
   c_fifo_full: cover property (!raw_ready && raw_valid);
endmodule

// *** sim/host_model.sv ***
// host side model: drives the shift clock and captures the serial result
module host_model
   import adc_readout_pkg::*;
(
   output logic serial_shift_clock,
   input wire logic ready_data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam time HALF = 400ns;
   // held low from time zero so the power-up calibration is not disturbed
   initial serial_shift_clock = 1'b0;
   // a bit is sampled just before the next rise, when the line has surely settled
   task automatic shift(input int n, output logic [WORD_W-1:0] word);
      word = '0;
      for (int i = 0; i < n; i++) begin
         serial_shift_clock = 1'b1;
         #HALF;
         serial_shift_clock = 1'b0;
         #HALF;
         if (i < WORD_W) word = {word[WORD_W-2:0], ready_data_out};
      end
   endtask
   task automatic set_clock(input logic v);
      serial_shift_clock = v;
   endtask
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the serial converter readout port
module testbench
   import adc_readout_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CONV = 400;
   localparam int CAL = 300;
   localparam int SLP = 40;
   localparam logic [RAW_W-1:0] RAW_T [8] = '{26'h0800004, 26'h37ffffd, 26'h0123456,
      26'h0000000, 26'h0000001, 26'h3ffffff, 26'h07fffff, 26'h3800000};
   localparam logic [WORD_W-1:0] EXP_T [8] = '{24'h7fffff, 24'h800000, 24'h123456,
      24'h000000, 24'h000001, 24'hffffff, 24'h7fffff, 24'h800000};
   logic clk_sys, rstn, raw_valid, raw_ready, ready_data_out, conv_start;
   logic calibrating, asleep, serial_shift_clock;
   raw_sample_t raw_in;
   logic [WORD_W-1:0] w;
   int mismatches, comparisons, cyc, last_rdy, gap;
   adc_serial_readout_port #(.CONV_CYCLES(CONV), .CAL_CYCLES(CAL), .SLEEP_CYCLES(SLP),
      .FIFO_DEPTH(8)) adc_serial_readout_port_i (.clk_sys(clk_sys), .rstn(rstn),
      .serial_shift_clock(serial_shift_clock), .raw_in(raw_in), .raw_valid(raw_valid),
      .raw_ready(raw_ready), .ready_data_out(ready_data_out), .conv_start(conv_start),
      .calibrating(calibrating), .asleep(asleep));
   host_model host_model_i (.serial_shift_clock(serial_shift_clock),
      .ready_data_out(ready_data_out));
   initial clk_sys = 1'b0;
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc <= cyc + 1;
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check_word(input string what, input logic [WORD_W-1:0] exp, seen);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic check_bit(input string what, input logic exp, seen);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %b, seen %b", what, exp, seen);
      end
   endtask
   task automatic check_count(input string what, input int exp, seen);
      comparisons++;
      if (seen != exp) begin
         mismatches++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, seen);
      end
   endtask
   // the host only shifts once the ready pulse is seen, never in the update window
   task automatic wait_ready(input int bound);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (conv_start !== 1'b1 && n < bound);
      if (conv_start !== 1'b1) begin
         mismatches++;
         $display("unexpected ready wait: expected pulse, seen none");
         complete_run();
      end else begin
         check_bit("line at ready", 1'b0, ready_data_out);
         gap = cyc - last_rdy;
         last_rdy = cyc;
      end
   endtask
   task automatic t_powerup();
      check_bit("calibrating", 1'b1, calibrating);
      for (int i = 0; i < 8; i++) begin
         raw_in.value = RAW_T[i];
         raw_valid = 1'b1;
         @(negedge clk_sys);
      end
      raw_in.value = 26'h0000abc;
      check_bit("raw ready when full", 1'b0, raw_ready);
      repeat (4) @(negedge clk_sys);
      raw_valid = 1'b0;
      check_bit("line during calibration", 1'b1, ready_data_out);
      wait_ready(2000);
      check_count("first ready", CAL + 16, gap);
      check_bit("calibration over", 1'b0, calibrating);
      $display("test powerup done");
   endtask
   task automatic t_reads();
      host_model_i.shift(25, w);
      check_word("result 0", EXP_T[0], w);
      repeat (20) @(negedge clk_sys);
      check_bit("line after 25th", 1'b1, ready_data_out);
      wait_ready(CONV + 20);
      check_count("period", CONV, gap);
      host_model_i.shift(24, w);
      check_word("result 1", EXP_T[1], w);
      repeat (20) @(negedge clk_sys);
      check_bit("line holds last bit", EXP_T[1][0], ready_data_out);
      wait_ready(CONV + 20);
      check_count("period", CONV, gap);
      host_model_i.shift(8, w);
      check_word("partial read", {16'h0000, EXP_T[2][23:16]}, w);
      wait_ready(CONV + 20);
      check_count("period", CONV, gap);
      $display("test reads done");
   endtask
   task automatic t_calibrate();
      host_model_i.shift(26, w);
      check_word("result 3", EXP_T[3], w);
      check_bit("calibrating after 26th", 1'b1, calibrating);
      last_rdy = cyc;
      wait_ready(CAL + 40);
      check_bit("calibration length", 1'b1, gap >= CAL + 8 && gap <= CAL + 16);
      host_model_i.shift(24, w);
      check_word("result 4", EXP_T[4], w);
      $display("test calibrate done");
   endtask
   task automatic t_sleep();
      wait_ready(CONV + 20);
      host_model_i.set_clock(1'b1);
      repeat (SLP + 20) @(negedge clk_sys);
      check_bit("asleep", 1'b1, asleep);
      check_bit("line in sleep", 1'b1, ready_data_out);
      host_model_i.set_clock(1'b0);
      repeat (10) @(negedge clk_sys);
      check_bit("awake", 1'b0, asleep);
      wait_ready(CONV + 20);
      host_model_i.shift(24, w);
      check_word("result after wake", EXP_T[6], w);
      $display("test sleep done");
   endtask
   task automatic t_drain();
      wait_ready(CONV + 20);
      host_model_i.shift(24, w);
      check_word("result 7", EXP_T[7], w);
      check_bit("raw ready when empty", 1'b1, raw_ready);
      wait_ready(CONV + 20);
      check_count("period", CONV, gap);
      host_model_i.shift(24, w);
      check_word("repeated result", EXP_T[7], w);
      $display("test drain done");
   endtask
   // 25 bits then a held-high clock: sleep, and calibration on wake
   task automatic t_sleep_cal();
      wait_ready(CONV + 20);
      raw_in.value = RAW_T[2];
      raw_valid = 1'b1;
      @(negedge clk_sys);
      raw_valid = 1'b0;
      host_model_i.shift(25, w);
      check_word("result before sleep", EXP_T[7], w);
      host_model_i.set_clock(1'b1);
      repeat (SLP + 20) @(negedge clk_sys);
      check_bit("asleep armed", 1'b1, asleep);
      host_model_i.set_clock(1'b0);
      repeat (10) @(negedge clk_sys);
      check_bit("calibrating on wake", 1'b1, calibrating);
      check_bit("line during wake cal", 1'b1, ready_data_out);
      wait_ready(CAL + 40);
      host_model_i.shift(24, w);
      check_word("result after wake cal", EXP_T[2], w);
      $display("test sleep calibrate done");
   endtask
   initial begin
      rstn = 1'b0;
      raw_valid = 1'b0;
      raw_in.value = '0;
      cyc = 0;
      mismatches = 0;
      comparisons = 0;
      repeat (8) @(negedge clk_sys);
      rstn = 1'b1;
      last_rdy = cyc;
      t_powerup();
      t_reads();
      t_calibrate();
      t_sleep();
      t_drain();
      t_sleep_cal();
      complete_run();
   end
endmodule
